// ---- rtl/pot_axil_slave.v ----
// AXI4-Lite slave front end for the wiper controller registers.
// Assumes rd_data is a combinational decode of rd_addr on the same clock.
`timescale 1ns/1ps
`include "pot_host_defs.vh"
module pot_axil_slave (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address and data
  input wire [3:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  // Write response
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  // Read address and data
  input wire [3:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // Register side
  output wire wr_en,
  output wire [3:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0] rd_addr,
  input wire [31:0] rd_data
);
  reg [3:0] awaddr_q;
  reg aw_ok_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_ok_q;
  wire wr_good;

  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `OFS_CMD) || (a == `OFS_STATUS) || (a == `OFS_POS);
    end
  endfunction

  assign s_awready = !aw_ok_q && !s_bvalid;
  assign s_wready = !w_ok_q && !s_bvalid;
  assign s_arready = !s_rvalid;
  // Fields reach into byte 1, so a write must carry the two low lanes
  assign wr_good = mapped(awaddr_q) && (wstrb_q[1:0] == 2'h3);
  assign wr_en = aw_ok_q && w_ok_q && wr_good;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign rd_addr = s_araddr;

  // ==================================================
  // Write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 4'h0;
      aw_ok_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_ok_q <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_q <= {s_awaddr[3:2], 2'h0};
        aw_ok_q <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        w_ok_q <= 1'b1;
      end
      if (aw_ok_q && w_ok_q) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_good ? 2'h0 : 2'h2;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ==================================================
  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= mapped({s_araddr[3:2], 2'h0}) ? rd_data : 32'h00000000;
      s_rresp <= mapped({s_araddr[3:2], 2'h0}) ? 2'h0 : 2'h2;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule // pot_axil_slave

// ---- rtl/pot_host_defs.vh ----
// Constants shared by the wiper controller files.
// Assumes a 40 MHz aclk; times are kept in their own units.
`ifndef POT_HOST_DEFS_VH
`define POT_HOST_DEFS_VH
// ==================================================
// Clock and pin timing
`define CLK_MHZ 18'h28
`define T_CU_NS 18'h32
`define T_CI_NS 18'h32
`define T_IL_NS 18'h64
`define T_IH_NS 18'h64
`define T_PC_US 18'h3E8
`define T_CL_US 18'h1388
`define T_CH_US 18'h1388
`define T_PH_US 18'h3E8
`define T_UP_US 18'h3E8
// ==================================================
// Tap positions and pulse counts
`define TAP_MID 5'h10
`define TAP_MAX 5'h1F
`define TAP_MIN 5'h00
`define PULSES_STORE 3'h5
`define PULSES_LOCK 3'h6
// ==================================================
// Register offsets
`define OFS_CMD 4'h0
`define OFS_STATUS 4'h4
`define OFS_POS 4'h8
// ==================================================
// Command fields
`define CMD_STEP 0
`define CMD_PROG 1
`define CMD_UP 2
`define CMD_LOCK 3
`define CMD_CNT_LSB 8
`define CMD_CNT_MSB 12
// ==================================================
// Status fields
`define ST_BUSY 0
`define ST_READY 1
`define ST_STORED 2
`define ST_LOCKED 3
`define ST_REFUSED 4
`define ST_MOVED 5
// ==================================================
// Position register fields
`define POS_LSB 0
`define POS_MSB 4
`define PPOS_LSB 8
`define PPOS_MSB 12
`endif

// ---- rtl/pot_timer.v ----
// Down-counting interval timer for the pin sequencer.
// Assumes load is a registered one-cycle strobe from the same clock.
`timescale 1ns/1ps
module pot_timer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire load,
  input wire [17:0] load_val,
  // Status
  output wire expired
);
  reg [17:0] cnt_q;

  // A fresh load masks expiry so the old count never leaks through
  assign expired = (cnt_q == 18'h00000) && !load;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 18'h00000;
    end else if (load) begin
      cnt_q <= load_val - 18'h00001;
    end else if (cnt_q != 18'h00000) begin
      cnt_q <= cnt_q - 18'h00001;
    end
  end
endmodule // pot_timer

// ---- rtl/pot_wiper_host.v ----
// Host controller for a 32-tap up/down wiper with one-time programming.
// Assumes the device pins are driven directly; the device gives nothing back,
// so position and programming state are a mirror kept by this controller.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pot_host_defs.vh"
// Operation
// [RL1] Mirror covers thirty-two taps
// [RL2] Steps issued only while select held low
// [RL3] Select falls with direction line giving mode
// [RL4] Direction mode kept until select rises
// [RL5] Each step rising edge moves one tap
// [RL6] Mirror holds position until reset
// [RL7] Device connects new tap before old
// [RL8] Mirror saturates at both ends
// [RL9] Mirror starts at tap sixteen
// [RL10] Position, direction high, supply, then select low
// [RL11] Five select pulses store the position
// [RL12] Supply removed after the pulses
// [RL13] Stored position reloads; steps still allowed
// [RL14] Sixth pulse sets lockout
// [RL15] Locked device rejects adjustment
// [RL16] Programming refused after six-pulse sequence
// [RL17] Return to stored position before locking
// [RL18] Midscale store keeps later programming open
// [RL19] Power-up position moves from midscale once
// [RL20] Interface usable until next power-up
// [RL21] Short sequences never issued
// [RL22] Device forces midscale then loads store
// [RL23] Wait power-up interval before commands
// [RL24] Position is five bits, midscale sixteen
// [RL25] Pulse count cleared with supply
module pot_wiper_host #(
  parameter [17:0] UP_CYC = `T_UP_US * `CLK_MHZ,
  parameter [17:0] PC_CYC = `T_PC_US * `CLK_MHZ,
  parameter [17:0] CL_CYC = `T_CL_US * `CLK_MHZ,
  parameter [17:0] CH_CYC = `T_CH_US * `CLK_MHZ,
  parameter [17:0] PH_CYC = `T_PH_US * `CLK_MHZ
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [3:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  // AXI4-Lite read
  input wire [3:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready,
  // Device pins
  output wire sel_n,
  output wire step_dir,
  output wire prog_supply_en
);
  // Short least times round up to whole cycles
  localparam [17:0] CU_CYC = (`T_CU_NS * `CLK_MHZ + 18'h3E7) / 18'h3E8;
  localparam [17:0] CI_CYC = (`T_CI_NS * `CLK_MHZ + 18'h3E7) / 18'h3E8;
  localparam [17:0] IL_CYC = (`T_IL_NS * `CLK_MHZ + 18'h3E7) / 18'h3E8;
  localparam [17:0] IH_CYC = (`T_IH_NS * `CLK_MHZ + 18'h3E7) / 18'h3E8;

  localparam [10:0] S_PWR = 11'h001;
  localparam [10:0] S_IDLE = 11'h002;
  localparam [10:0] S_SETUP = 11'h004;
  localparam [10:0] S_HOLD = 11'h008;
  localparam [10:0] S_SLOW = 11'h010;
  localparam [10:0] S_SHIGH = 11'h020;
  localparam [10:0] S_SEND = 11'h040;
  localparam [10:0] S_ARM = 11'h080;
  localparam [10:0] S_PLOW = 11'h100;
  localparam [10:0] S_PHIGH = 11'h200;
  localparam [10:0] S_DROP = 11'h400;

  reg [10:0] state_q;
  reg sel_n_q;
  reg step_dir_q;
  reg supply_q;
  reg tload_q;
  reg [17:0] tval_q;
  reg [4:0] cnt_q;
  reg up_q;
  reg chain_q;
  reg [2:0] pulses_q;
  reg [2:0] target_q;
  reg [4:0] pos_q;
  reg [4:0] prog_pos_q;
  reg stored_q;
  reg moved_q;
  reg locked_q;
  reg refused_q;
  reg ready_q;
  reg [31:0] rd_data;
  wire wr_en;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] rd_addr;
  wire texp;
  wire cmd_wr;
  wire [4:0] cmd_cnt;
  wire lock_back;

  function hit;
    input [3:0] a;
    input [3:0] ofs;
    begin
      hit = ({a[3:2], 2'h0} == ofs);
    end
  endfunction

  assign sel_n = sel_n_q;
  assign step_dir = step_dir_q;
  assign prog_supply_en = supply_q;
  assign cmd_wr = wr_en && hit(wr_addr, `OFS_CMD);
  assign cmd_cnt = wr_data[`CMD_CNT_MSB:`CMD_CNT_LSB];
  // A five-pulse store elsewhere than here must be walked back first
  assign lock_back = wr_data[`CMD_LOCK] && moved_q && (pos_q != prog_pos_q); // RL17

  pot_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  pot_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tload_q),
    .load_val(tval_q),
    .expired(texp)
  );

  // ==================================================
  // Register read decode
  always @* begin
    rd_data = 32'h00000000;
    if (hit(rd_addr, `OFS_STATUS)) begin
      rd_data[`ST_BUSY] = (state_q != S_IDLE);
      rd_data[`ST_READY] = ready_q;
      rd_data[`ST_STORED] = stored_q;
      rd_data[`ST_LOCKED] = locked_q;
      rd_data[`ST_REFUSED] = refused_q;
      rd_data[`ST_MOVED] = moved_q;
    end else if (hit(rd_addr, `OFS_POS)) begin
      rd_data[`POS_MSB:`POS_LSB] = pos_q;
      rd_data[`PPOS_MSB:`PPOS_LSB] = prog_pos_q;
    end
  end

  // ==================================================
  // Pin sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_PWR;
      sel_n_q <= 1'b1;
      step_dir_q <= 1'b0;
      supply_q <= 1'b0;
      tload_q <= 1'b1;
      tval_q <= UP_CYC;
      cnt_q <= 5'h00;
      up_q <= 1'b0;
      chain_q <= 1'b0;
      pulses_q <= 3'h0;
      target_q <= `PULSES_STORE;
      pos_q <= `TAP_MID; // RL9 RL24
      prog_pos_q <= `TAP_MID;
      stored_q <= 1'b0;
      moved_q <= 1'b0;
      locked_q <= 1'b0;
      refused_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      tload_q <= 1'b0;
      // Write-one clears; a refusal in the same cycle lands later and wins
      if (wr_en && hit(wr_addr, `OFS_STATUS) && wr_data[`ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      // Resync after the device was power cycled behind our back
      if (wr_en && hit(wr_addr, `OFS_POS) && state_q == S_IDLE && !cmd_wr) begin
        pos_q <= wr_data[`POS_MSB:`POS_LSB]; // RL6
      end
      if (cmd_wr && state_q != S_IDLE) begin
        refused_q <= 1'b1;
      end
      case (state_q)
        S_PWR: begin
          if (texp) begin
            ready_q <= 1'b1; // RL23 RL22
            state_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (cmd_wr) begin
            if (wr_data[`CMD_STEP] && cmd_cnt != 5'h00) begin
              // A locked device still steps until its next power-up
              step_dir_q <= wr_data[`CMD_UP]; // RL20
              up_q <= wr_data[`CMD_UP];
              cnt_q <= cmd_cnt;
              tload_q <= 1'b1;
              tval_q <= CU_CYC;
              state_q <= S_SETUP;
            end else if (wr_data[`CMD_PROG] && !locked_q) begin // RL16 RL15
              target_q <= wr_data[`CMD_LOCK] ? `PULSES_LOCK : `PULSES_STORE;
              tload_q <= 1'b1;
              if (lock_back) begin
                chain_q <= 1'b1; // RL17
                up_q <= (prog_pos_q > pos_q);
                step_dir_q <= (prog_pos_q > pos_q);
                cnt_q <= (prog_pos_q > pos_q) ? prog_pos_q - pos_q : pos_q - prog_pos_q;
                tval_q <= CU_CYC;
                state_q <= S_SETUP;
              end else begin
                step_dir_q <= 1'b1; // RL10
                pulses_q <= 3'h0; // RL25
                tval_q <= PC_CYC;
                state_q <= S_ARM;
              end
            end else begin
              refused_q <= 1'b1;
            end
          end
        end
        S_SETUP: begin
          if (texp) begin
            sel_n_q <= 1'b0; // RL3
            tload_q <= 1'b1;
            tval_q <= CI_CYC;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (texp) begin
            step_dir_q <= 1'b0; // RL4
            tload_q <= 1'b1;
            tval_q <= IL_CYC;
            state_q <= S_SLOW;
          end
        end
        S_SLOW: begin
          if (texp) begin
            step_dir_q <= 1'b1; // RL2 RL5
            // The device switches make-before-break; the mirror just moves
            if (up_q && pos_q != `TAP_MAX) begin // RL7 RL8 RL1
              pos_q <= pos_q + 5'h01;
            end else if (!up_q && pos_q != `TAP_MIN) begin
              pos_q <= pos_q - 5'h01;
            end
            tload_q <= 1'b1;
            tval_q <= IH_CYC;
            state_q <= S_SHIGH;
          end
        end
        S_SHIGH: begin
          if (texp) begin
            tload_q <= 1'b1;
            if (cnt_q == 5'h01) begin
              sel_n_q <= 1'b1;
              tval_q <= CU_CYC;
              state_q <= S_SEND;
            end else begin
              cnt_q <= cnt_q - 5'h01;
              step_dir_q <= 1'b0;
              tval_q <= IL_CYC;
              state_q <= S_SLOW;
            end
          end
        end
        S_SEND: begin
          // Gap before the next select fall also covers its setup time
          if (texp) begin
            if (chain_q) begin
              chain_q <= 1'b0;
              step_dir_q <= 1'b1; // RL10
              pulses_q <= 3'h0; // RL25
              tload_q <= 1'b1;
              tval_q <= PC_CYC;
              state_q <= S_ARM;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_ARM: begin
          // Supply rises a cycle after the direction line, never with it
          supply_q <= 1'b1; // RL10
          if (texp) begin
            sel_n_q <= 1'b0; // RL10
            tload_q <= 1'b1;
            tval_q <= CL_CYC;
            state_q <= S_PLOW;
          end
        end
        S_PLOW: begin
          if (texp) begin
            tload_q <= 1'b1;
            // The last low phase also serves as select-fall to supply-fall
            if (pulses_q == target_q) begin // RL11 RL21
              supply_q <= 1'b0; // RL12
              tval_q <= PH_CYC;
              state_q <= S_DROP;
            end else begin
              sel_n_q <= 1'b1;
              tval_q <= CH_CYC;
              state_q <= S_PHIGH;
            end
          end
        end
        S_PHIGH: begin
          if (texp) begin
            sel_n_q <= 1'b0;
            pulses_q <= pulses_q + 3'h1; // RL11
            tload_q <= 1'b1;
            tval_q <= CL_CYC;
            state_q <= S_PLOW;
          end
        end
        S_DROP: begin
          if (texp) begin
            sel_n_q <= 1'b1;
            pulses_q <= 3'h0; // RL25
            stored_q <= 1'b1; // RL13 RL18
            if (!moved_q && pos_q != `TAP_MID) begin // RL19
              moved_q <= 1'b1;
              prog_pos_q <= pos_q;
            end
            if (target_q == `PULSES_LOCK) begin
              locked_q <= 1'b1; // RL14
            end
            tload_q <= 1'b1;
            tval_q <= CU_CYC;
            state_q <= S_SEND;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // pot_wiper_host

// ---- testbench/pot_device_model.sv ----
// Behavioural model of the 32-tap one-time programmable wiper.
// Assumes aresetn low stands for a power cycle of the device.
`timescale 1ns/1ps
module pot_device_model (
  // Power
  input wire aresetn,
  // Pins
  input wire sel_n,
  input wire step_dir,
  input wire prog_supply_en
);
  reg [4:0] pos;
  reg [4:0] stored;
  reg up_mode;
  reg lock_flag;
  reg iface_off;
  reg changed;
  reg [2:0] pulses;
  initial begin
    stored = 5'h10;
    pos = 5'h10;
    up_mode = 1'b0;
    lock_flag = 1'b0;
    iface_off = 1'b0;
    changed = 1'b0;
    pulses = 3'h0;
  end
  // ==========
  // Power-up: midscale first, then the stored tap
  always @(negedge aresetn) begin
    pos = 5'h10;
    pos = stored;
    iface_off = lock_flag;
  end
  always @(negedge sel_n) if (!iface_off && !prog_supply_en) up_mode = step_dir;
  // One assignment per step, so the wiper never sits between taps
  always @(posedge step_dir) if (!sel_n && !iface_off && !prog_supply_en) begin
    if (up_mode && pos != 5'h1F) pos = pos + 5'h01;
    else if (!up_mode && pos != 5'h00) pos = pos - 5'h01;
  end
  // ==========
  // One-time programming
  always @(posedge sel_n) if (prog_supply_en && !lock_flag) pulses = pulses + 3'h1;
  always @(negedge prog_supply_en) begin
    if (pulses >= 3'h5 && !changed) begin
      stored = pos;
      changed = (pos != 5'h10);
    end
    if (pulses >= 3'h6) lock_flag = 1'b1;
    pulses = 3'h0;
  end
endmodule // pot_device_model

// ---- testbench/pot_wiper_host_monitor.sv ----
// Checker for the device-pin sequencing of the wiper controller.
// Assumes it is bound to pot_wiper_host and sees only that module's ports.
`timescale 1ns/1ps
module pot_wiper_host_monitor #(
  parameter [17:0] UP_CYC = 18'h8,
  parameter [17:0] PC_CYC = 18'h8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Device pins
  input wire sel_n,
  input wire step_dir,
  input wire prog_supply_en
);
  reg [17:0] up_q;
  reg [17:0] sup_q;
  reg [2:0] pls_q;
  reg sel_prev_q;
  // ==========
  // Helper counters
  always @(posedge aclk) begin
    sel_prev_q <= sel_n;
    if (!aresetn) up_q <= 18'h0;
    else if (up_q != 18'h3FFFF) up_q <= up_q + 18'h1;
    if (!aresetn || !prog_supply_en) sup_q <= 18'h0;
    else if (sel_n && sup_q != 18'h3FFFF) sup_q <= sup_q + 18'h1;
    // Counts select rises only while the supply is applied
    if (!aresetn || !prog_supply_en) pls_q <= 3'h0;
    else if (sel_n && !sel_prev_q) pls_q <= pls_q + 3'h1;
  end
  // ==========
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_pins_idle: assert property (disable iff (1'b0)
    !aresetn |=> sel_n && !step_dir && !prog_supply_en) else $error("pins not idle in reset");
  a_powerup_wait_kept: assert property ($fell(sel_n) |-> up_q > UP_CYC)
    else $error("select fell inside power-up wait");
  a_mode_setup_held: assert property ($fell(sel_n) |-> step_dir == $past(step_dir, 2))
    else $error("direction moved just before select fell");
  a_step_low_time: assert property ($fell(step_dir) && !sel_n |-> !step_dir [*4])
    else $error("step low phase too short");
  a_step_high_time: assert property ($rose(step_dir) && !sel_n |-> step_dir [*4])
    else $error("step high phase too short");
  a_supply_arm_order: assert property ($rose(prog_supply_en) |-> sel_n && step_dir && $past(step_dir))
    else $error("supply raised out of order");
  a_supply_to_select: assert property ($fell(sel_n) && prog_supply_en |-> sup_q >= PC_CYC)
    else $error("select fell too soon after supply");
  a_prog_dir_held: assert property (prog_supply_en && $past(prog_supply_en) |-> step_dir)
    else $error("direction low while programming");
  a_pulse_total: assert property ($fell(prog_supply_en) |-> pls_q == 3'h5 || pls_q == 3'h6)
    else $error("wrong number of programming pulses");
  a_supply_off_sel: assert property ($fell(prog_supply_en) |-> !sel_n ##1 !sel_n)
    else $error("select high when supply removed");
endmodule // pot_wiper_host_monitor

bind pot_wiper_host pot_wiper_host_monitor #(.UP_CYC(UP_CYC), .PC_CYC(PC_CYC)) i_mon (
  .aclk(aclk), .aresetn(aresetn), .sel_n(sel_n), .step_dir(step_dir),
  .prog_supply_en(prog_supply_en));

// ---- testbench/pot_wiper_host_tb.sv ----
// Self-checking bench for the wiper controller over AXI4-Lite.
// Assumes the device model stands on the pins; shortened timing parameters.
`timescale 1ns/1ps
`include "pot_host_defs.vh"
module pot_wiper_host_tb;
  reg aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  reg [3:0] s_awaddr, s_araddr, s_wstrb;
  reg [31:0] s_wdata, rd;
  wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sel_n, step_dir, prog_supply_en;
  wire [1:0] s_bresp, s_rresp;
  wire [31:0] s_rdata;
  integer error_cnt, n_compared, seed, n;
  reg [33:0] rexp_q[$];
  reg [33:0] rmsk_q[$];
  reg [1:0] bexp_q[$];
  reg [33:0] m, e;
  reg [4:0] exp_pos, exp_sto;
  reg exp_chg;
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  pot_wiper_host #(.UP_CYC(18'h10), .PC_CYC(18'h8), .CL_CYC(18'h10), .CH_CYC(18'h10),
    .PH_CYC(18'h8)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .sel_n(sel_n), .step_dir(step_dir), .prog_supply_en(prog_supply_en));
  pot_device_model i_dev (.aresetn(aresetn), .sel_n(sel_n), .step_dir(step_dir),
    .prog_supply_en(prog_supply_en));
  // ==========
  // Comparison and reporting
  task check(input string name, input [33:0] seen, input [33:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Oldest note is matched against each response as it is handed over
  always @(posedge aclk) begin
    if (s_rvalid === 1'b1 && s_rready === 1'b1 && rexp_q.size() > 0) begin
      m = rmsk_q.pop_front();
      e = rexp_q.pop_front();
      if (m != 34'h0) check("read", {s_rresp, s_rdata} & m, e & m);
    end
    if (s_bvalid === 1'b1 && s_bready === 1'b1 && bexp_q.size() > 0)
      check("bresp", {32'h0, s_bresp}, {32'h0, bexp_q.pop_front()});
  end
  // ==========
  // Bus tasks
  task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
    reg done;
    begin
      @(posedge aclk);
      bexp_q.push_back(er);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (s_awvalid && s_awready) s_awvalid <= 1'b0;
        if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        if (s_bvalid === 1'b1) done = 1'b1;
      end
      s_bready <= 1'b0;
    end
  endtask
  task axi_rd(input [3:0] a, input [33:0] ex, input [33:0] mk, output [31:0] d);
    reg done;
    begin
      @(posedge aclk);
      rexp_q.push_back(ex);
      rmsk_q.push_back(mk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        if (s_rvalid === 1'b1) begin
          done = 1'b1;
          d = s_rdata;
        end
      end
      s_rready <= 1'b0;
    end
  endtask
  // Polls STATUS until the given bit reaches the given level
  task poll(input integer b, input v);
    integer k;
    begin
      rd = {32{~v}};
      for (k = 0; k < 400 && rd[b] !== v; k = k + 1) axi_rd(`OFS_STATUS, 34'h0, 34'h0, rd);
      check("poll", {33'h0, rd[b]}, {33'h0, v});
    end
  endtask
  function [31:0] stp(input up, input [4:0] c);
    stp = {19'h0, c, 4'h0, 1'b0, up, 2'b01};
  endfunction
  task move(input up, input [4:0] c);
    integer k;
    begin
      for (k = 0; k < c; k = k + 1)
        if (up && exp_pos != 5'h1F) exp_pos = exp_pos + 5'h01;
        else if (!up && exp_pos != 5'h00) exp_pos = exp_pos - 5'h01;
      axi_wr(`OFS_CMD, stp(up, c), 2'b00);
      poll(`ST_BUSY, 1'b0);
      check("dev_pos", {29'h0, i_dev.pos}, {29'h0, exp_pos});
      axi_rd(`OFS_POS, {29'h0, exp_pos}, 34'h1F, rd);
    end
  endtask
  task prog(input lk);
    begin
      if (!exp_chg) begin
        exp_sto = exp_pos;
        exp_chg = (exp_pos != `TAP_MID);
      end
      if (lk) exp_pos = exp_sto;
      axi_wr(`OFS_CMD, {28'h0, lk, 3'b010}, 2'b00);
      poll(`ST_BUSY, 1'b0);
      check("stored", {29'h0, i_dev.stored}, {29'h0, exp_sto});
      check("lock", {33'h0, i_dev.lock_flag}, {33'h0, lk});
      check("dev_pos", {29'h0, i_dev.pos}, {29'h0, exp_pos});
      axi_rd(`OFS_POS, {21'h0, exp_sto, 8'h0}, 34'h1F00, rd);
      axi_rd(`OFS_STATUS, {26'h0, exp_chg, 1'b0, lk, 3'h4}, 34'h2C, rd);
    end
  endtask
  // ==========
  // Watchdog and main sequence
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt = error_cnt + 1;
    results;
  end
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
    {s_awaddr, s_araddr, s_wdata} = 40'h0;
    s_wstrb = 4'hF;
    {error_cnt, n_compared, seed} = {32'h0, 32'h0, 32'd64911};
    {exp_pos, exp_sto, exp_chg} = {5'h10, 5'h10, 1'b0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(`OFS_CMD, stp(1'b1, 5'h01), 2'b00);
    axi_rd(`OFS_STATUS, 34'h10, 34'h12, rd);
    poll(`ST_READY, 1'b1);
    axi_wr(`OFS_STATUS, 32'h10, 2'b00);
    axi_rd(`OFS_STATUS, 34'h2, 34'h12, rd);
    check("dev_pos", {29'h0, i_dev.pos}, 34'h10);
    s_wstrb <= 4'h1;
    axi_wr(`OFS_CMD, stp(1'b1, 5'h01), 2'b10);
    s_wstrb <= 4'hF;
    axi_rd(`OFS_STATUS, 34'h0, 34'h1, rd);
    axi_rd(`OFS_POS, 34'h1010, 34'h1F1F, rd);
    axi_rd(4'hC, {2'b10, 32'h0}, {34{1'b1}}, rd);
    axi_wr(4'hC, $random(seed), 2'b10);
    $display("test reset done");
    move(1'b1, 5'h14);
    move(1'b0, 5'h03);
    n = 1 + ($random(seed) & 15);
    move(1'b0, n[4:0]);
    $display("test stepping done");
    prog(1'b0);
    move(1'b1, 5'h02);
    prog(1'b0);
    move(1'b1, 5'h03);
    prog(1'b1);
    axi_wr(`OFS_CMD, 32'h2, 2'b00);
    axi_rd(`OFS_STATUS, 34'h10, 34'h10, rd);
    $display("test programming done");
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    check("dev_pos", {29'h0, i_dev.pos}, {29'h0, exp_sto});
    poll(`ST_READY, 1'b1);
    axi_wr(`OFS_POS, {27'h0, exp_sto}, 2'b00);
    axi_wr(`OFS_CMD, stp(1'b1, 5'h01), 2'b00);
    poll(`ST_BUSY, 1'b0);
    check("dev_pos", {29'h0, i_dev.pos}, {29'h0, exp_sto});
    $display("test power cycle done");
    results;
  end
endmodule // pot_wiper_host_tb
